// ===== port_a_pin_function_select.sv
// port a pin function select register and upper-half pin multiplexer
//
// Decided for this implementation: strobed register access.
`timescale 1ns/10ps
module port_a_pin_function_select (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic      [31:0] reg_rdata,
	output logic      [15:0] port_a_function_select,
	output logic      [15:0] port_a_schmitt_enable,
	output logic      [1:0]  pin15_function,
	output logic      [1:0]  pin14_function,
	output logic      [1:0]  pin13_function,
	input  wire logic [15:0] gpio_out,
	input  wire logic        pulse_channel_3,
	input  wire logic        pulse_channel_2,
	input  wire logic        pulse_channel_1,
	input  wire logic        audio_master_clock,
	input  wire logic        ext_bus_ad_bit15,
	input  wire logic        ext_bus_ad_bit14,
	output logic      [2:0]  pin_out_upper
);
	logic [31:0]                    port_a_function_and_input_type;
	logic [31:0]                    alternate_function_control;
	pin_function_pkg::pin_func_type f15;
	pin_function_pkg::pin_func_type f14;
	pin_function_pkg::pin_func_type f13;

	//==============================================================
	// function register, zero at reset
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			port_a_function_and_input_type <= pin_function_pkg::FUNC_REG_RESET;
		else if (reg_write && reg_addr == pin_function_pkg::FUNC_REG_OFFSET)
			port_a_function_and_input_type <= reg_wdata;
	end

	// alternate control holds only the bits this block decodes
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			alternate_function_control <= pin_function_pkg::ALT_REG_RESET;
		else if (reg_write && reg_addr == pin_function_pkg::ALT_REG_OFFSET)
			alternate_function_control <= reg_wdata & pin_function_pkg::ALT_REG_MASK;
	end

	// read data one cycle after strobe, zero for unmapped
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			reg_rdata <= 32'h0000_0000;
		else if (reg_read && reg_addr == pin_function_pkg::FUNC_REG_OFFSET)
			reg_rdata <= port_a_function_and_input_type;
		else if (reg_read && reg_addr == pin_function_pkg::ALT_REG_OFFSET)
			reg_rdata <= alternate_function_control;
		else
			reg_rdata <= 32'h0000_0000;
	end

	//==============================================================
	// schmitt enables from upper half
	assign port_a_schmitt_enable  = port_a_function_and_input_type[31:pin_function_pkg::SCHMITT_LSB];
	assign port_a_function_select = port_a_function_and_input_type[15:0];

	// decode of pins 15 to 13
	pin_upper_decode u_decode (
		.sel15                    (port_a_function_and_input_type[pin_function_pkg::SELECT_PIN15]),
		.sel14                    (port_a_function_and_input_type[pin_function_pkg::SELECT_PIN14]),
		.sel13                    (port_a_function_and_input_type[pin_function_pkg::SELECT_PIN13]),
		.pin15_audio_clock_select (alternate_function_control[pin_function_pkg::ALT_AUDIO_CLK_BIT]),
		.external_bus_enable      (alternate_function_control[pin_function_pkg::ALT_EXT_BUS_BIT]),
		.hb_enable_6              (alternate_function_control[pin_function_pkg::ALT_HB6_BIT]),
		.hb_enable_7              (alternate_function_control[pin_function_pkg::ALT_HB7_BIT]),
		.pin15_func               (f15),
		.pin14_func               (f14),
		.pin13_func               (f13)
	);

	assign pin15_function = f15;
	assign pin14_function = f14;
	assign pin13_function = f13;

	//==============================================================
	// output routing follows decode directly
	always_comb begin
		case (f15)
			pin_function_pkg::FUNC_PULSE: pin_out_upper[2] = pulse_channel_3;
			pin_function_pkg::FUNC_ALT:   pin_out_upper[2] = audio_master_clock;
			default:                      pin_out_upper[2] = gpio_out[15];
		endcase
		case (f14)
			pin_function_pkg::FUNC_PULSE: pin_out_upper[1] = pulse_channel_2;
			pin_function_pkg::FUNC_ALT:   pin_out_upper[1] = ext_bus_ad_bit15;
			default:                      pin_out_upper[1] = gpio_out[14];
		endcase
		case (f13)
			pin_function_pkg::FUNC_PULSE: pin_out_upper[0] = pulse_channel_1;
			pin_function_pkg::FUNC_ALT:   pin_out_upper[0] = ext_bus_ad_bit14;
			default:                      pin_out_upper[0] = gpio_out[13];
		endcase
	end
endmodule

// ===== pin_function_pkg.sv
// constants for the port a upper-half pin function multiplexer
//==============================================================
// Summary of operation
// - function and input-type register resets to all zeros.
// - bits 31..16 enable the input schmitt trigger of pins 0..15.
// - pin 15 select clear gives gpio, whatever the audio clock select.
// - pin 15 select set gives pulse channel 3, or audio clock when chosen.
// - pin 14 gpio, pulse channel 2, or ad bit 15 with bus and hb7.
// - pin 13 gpio when clear; pulse channel 1 when set and bus off.
// - pin 13 set with bus on gives ad bit 14 if hb6, else pulse 1.
package pin_function_pkg;
	//==============================================================
	// register map
	localparam logic [7:0]  FUNC_REG_OFFSET  = 8'h30;
	localparam logic [7:0]  ALT_REG_OFFSET   = 8'h50;
	localparam logic [31:0] FUNC_REG_RESET   = 32'h0000_0000;
	localparam logic [31:0] ALT_REG_RESET    = 32'h0000_0000;
	localparam logic [31:0] ALT_REG_MASK     = 32'h00C0_0A00;
	//==============================================================
	// field positions
	localparam int SCHMITT_LSB       = 16;
	localparam int SELECT_PIN15      = 15;
	localparam int SELECT_PIN14      = 14;
	localparam int SELECT_PIN13      = 13;
	localparam int ALT_AUDIO_CLK_BIT = 9;
	localparam int ALT_EXT_BUS_BIT   = 11;
	localparam int ALT_HB6_BIT       = 22;
	localparam int ALT_HB7_BIT       = 23;
	//==============================================================
	// pin function codes
	typedef enum logic [1:0] {
		FUNC_GPIO  = 2'h0,
		FUNC_PULSE = 2'h1,
		FUNC_ALT   = 2'h2
	} pin_func_type;
endpackage

// ===== pin_upper_decode.sv
// combinational function decode for port a pins 15 to 13
`timescale 1ns/10ps
module pin_upper_decode (
	input  wire logic                         sel15,
	input  wire logic                         sel14,
	input  wire logic                         sel13,
	input  wire logic                         pin15_audio_clock_select,
	input  wire logic                         external_bus_enable,
	input  wire logic                         hb_enable_6,
	input  wire logic                         hb_enable_7,
	output pin_function_pkg::pin_func_type    pin15_func,
	output pin_function_pkg::pin_func_type    pin14_func,
	output pin_function_pkg::pin_func_type    pin13_func
);
	//==============================================================
	// pure combinational decode
	always_comb begin
		if (!sel15)
			pin15_func = pin_function_pkg::FUNC_GPIO;
		else if (pin15_audio_clock_select)
			pin15_func = pin_function_pkg::FUNC_ALT;
		else
			pin15_func = pin_function_pkg::FUNC_PULSE;
		if (!sel14)
			pin14_func = pin_function_pkg::FUNC_GPIO;
		else if (external_bus_enable && hb_enable_7)
			pin14_func = pin_function_pkg::FUNC_ALT;
		else
			pin14_func = pin_function_pkg::FUNC_PULSE;
		// pin 13 gpio or pulse 1
		// ad bit 14 with bus and hb6
		if (!sel13)
			pin13_func = pin_function_pkg::FUNC_GPIO;
		else if (external_bus_enable && hb_enable_6)
			pin13_func = pin_function_pkg::FUNC_ALT;
		else
			pin13_func = pin_function_pkg::FUNC_PULSE;
	end
endmodule

// ===== port_a_pin_function_select_properties.sv
// checker for the port a pin function select block
`timescale 1ns/10ps
module pin_select_checker (
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_write,
	input wire logic        reg_read,
	input wire logic [31:0] reg_rdata,
	input wire logic [15:0] port_a_function_select,
	input wire logic [15:0] port_a_schmitt_enable,
	input wire logic [1:0]  pin15_function,
	input wire logic [1:0]  pin14_function,
	input wire logic [1:0]  pin13_function
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// accesses to the function register
	wire logic wr_func = reg_write && reg_addr == pin_function_pkg::FUNC_REG_OFFSET;
	wire logic rd_func = reg_read && reg_addr == pin_function_pkg::FUNC_REG_OFFSET;
	a_reset_clear: assert property ($fell(rst) |-> {port_a_schmitt_enable,
		port_a_function_select} == 32'h0000_0000) else $error("register not clear");
	a_schmitt_follows: assert property (wr_func |=>
		port_a_schmitt_enable == $past(reg_wdata[31:16])) else $error("schmitt bits wrong");
	a_select_follows: assert property (wr_func |=>
		port_a_function_select == $past(reg_wdata[15:0])) else $error("select bits wrong");
	a_pin15_gpio: assert property (!port_a_function_select[15] |-> pin15_function == 2'h0)
		else $error("pin 15 not gpio");
	a_pin15_alt: assert property (port_a_function_select[15] |-> pin15_function inside
		{2'h1, 2'h2}) else $error("pin 15 bad code");
	a_pin14_choice: assert property (!port_a_function_select[14] == (pin14_function == 2'h0))
		else $error("pin 14 choice wrong");
	a_pin13_choice: assert property (!port_a_function_select[13] == (pin13_function == 2'h0))
		else $error("pin 13 choice wrong");
	a_read_back: assert property (rd_func |=> reg_rdata ==
		$past({port_a_schmitt_enable, port_a_function_select})) else $error("read data wrong");
	cover property (wr_func);
	cover property (pin14_function == 2'h2);
	cover property (pin13_function == 2'h2);
endmodule
bind port_a_pin_function_select pin_select_checker pin_select_checker_inst (.sys_clk, .rst,
	.reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .port_a_function_select,
	.port_a_schmitt_enable, .pin15_function, .pin14_function, .pin13_function);

// ===== tb_port_a_pin_function_select.sv
// self-checking bench for the port a pin function select block
`timescale 1ns/10ps
module tb_port_a_pin_function_select;
	logic        sys_clk = 0, rst = 1, we = 0, re = 0;
	logic [7:0]  addr = 0;
	logic [31:0] wd = 0, rdata;
	logic [15:0] sel, schm;
	logic [15:0] gp = 16'hA000;
	logic [5:0]  src = 0, e;
	logic [1:0]  f15, f14, f13;
	logic [2:0]  po;
	int          errors = 0, n_compared = 0;
	initial forever #25 sys_clk = ~sys_clk;
	port_a_pin_function_select port_a_pin_function_select_inst (.sys_clk(sys_clk), .rst(rst),
		.reg_addr(addr), .reg_wdata(wd), .reg_write(we), .reg_read(re), .reg_rdata(rdata),
		.port_a_function_select(sel), .port_a_schmitt_enable(schm), .pin15_function(f15),
		.pin14_function(f14), .pin13_function(f13), .gpio_out(gp), .pulse_channel_3(src[5]),
		.audio_master_clock(src[4]), .pulse_channel_2(src[3]), .ext_bus_ad_bit15(src[2]),
		.pulse_channel_1(src[1]), .ext_bus_ad_bit14(src[0]), .pin_out_upper(po));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask
	// one-cycle bus accesses
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		wd <= d;
		we <= 1'b1;
		@(posedge sys_clk);
		we <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge sys_clk);
		addr <= a;
		re <= 1'b1;
		@(posedge sys_clk);
		re <= 1'b0;
		#1 chk(rdata, exp);
	endtask
	task automatic complete_run;
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		rd(8'h30, 32'h0000_0000);
		chk({schm, sel}, 32'h0000_0000);
		chk({f15, f14, f13}, 32'h0);
		wr(8'h30, 32'hA5C3_E000);
		chk(schm, 32'hA5C3);
		rd(8'h30, 32'hA5C3_E000);
		for (int i = 0; i < 32; i++) begin
			@(posedge sys_clk);
			src <= i[4] ? 6'h26 : 6'h19;
			wr(8'h50, {8'h00, i[3], i[2], 10'h000, i[1], 1'b0, i[0], 9'h000});
			e = {i[0] ? 2'h2 : 2'h1, i[1] & i[3] ? 2'h2 : 2'h1, i[1] & i[2] ? 2'h2 : 2'h1};
			chk({f15, f14, f13}, e);
			chk(po, {src[5 - i[0]], src[3 - (i[1] & i[3])], src[1 - (i[1] & i[2])]});
		end
		wr(8'h30, 32'h0000_0000);
		chk({f15, f14, f13, po}, {6'h00, gp[15:13]});
		wr(8'h44, 32'hFFFF_FFFF);
		rd(8'h44, 32'h0000_0000);
		rd(8'h50, 32'h00C0_0A00);
		wr(8'h30, 32'h1234_5678);
		// mid-run reset must clear both registers again
		@(posedge sys_clk);
		rst <= 1'b1;
		@(posedge sys_clk);
		rst <= 1'b0;
		rd(8'h50, 32'h0000_0000);
		chk({schm, sel}, 32'h0000_0000);
		chk({f15, f14, f13}, 32'h0);
		complete_run;
	end
	// watchdog against a hang
	initial begin
		repeat (500) @(posedge sys_clk);
		errors++;
		complete_run;
	end
endmodule
